// *** pcl_defs.svh ***
// Timing and encoding constants of the parallel configuration load sequencer
`ifndef PCL_DEFS_SVH
`define PCL_DEFS_SVH

// ----------------------------------------------------------------------------
// Clock and timing figures
// ----------------------------------------------------------------------------
`define PCL_CLK_MHZ 100
`define PCL_T_CF2X_MAX_NS 800
`define PCL_T_STATUS_MIN_US 10
`define PCL_T_STATUS_MAX_US 500
`define PCL_T_CD2UM_MIN_US 55
`define PCL_T_CD2UM_MAX_US 150
`define PCL_USR_INIT_PERIODS 8532
`define PCL_POR_US 12

// ----------------------------------------------------------------------------
// Link and pin encodings
// ----------------------------------------------------------------------------
`define PCL_INIT_FALL_EDGES 2'h2
`define PCL_CMP_PHASE_LAST 2'h3
`define PCL_CMP_PHASE_CAPTURE 2'h0
`define PCL_DEFAULT_BYTES 16
`define PCL_USER_IO_UPPER 7'h7f
`define PCL_SYNC_RST 7'h01
`define PCL_OD_LOW 1'h0

`endif

// *** pcl_pkg.sv ***
// Types shared by the parallel configuration load sequencer
package pcl_pkg;

  // --------------------------------------------------------------------------
  // Sequencer states
  // --------------------------------------------------------------------------
  typedef enum logic [2:0] {
    PCL_POR,
    PCL_RESET,
    PCL_RELEASE,
    PCL_LOAD,
    PCL_DONE_WAIT,
    PCL_INIT,
    PCL_USER
  } pcl_state_t;

  // --------------------------------------------------------------------------
  // Carriers
  // --------------------------------------------------------------------------
  typedef struct packed {
    logic valid;
    logic [7:0] data;
  } pcl_byte_t;

  typedef struct packed {
    logic out;
    logic oe;
  } pcl_od_t;

endpackage : pcl_pkg

// *** pcl_link_capture.sv ***
// Byte capture and init edge counting in the load clock domain
`include "pcl_defs.svh"
`timescale 1ns/1ps
`default_nettype none

module pcl_link_capture #(
  parameter int LOAD_BYTES = `PCL_DEFAULT_BYTES
) (
  // Clocks and reset
  input wire logic load_clock,
  input wire logic rstn,
  // From the system domain
  input wire logic load_en,
  // Pins
  input wire logic [7:0] load_data,
  input wire logic compressed_mode,
  input wire logic done_in,
  // Results
  output var pcl_pkg::pcl_byte_t cfg_byte,
  output logic loaded,
  output logic init_go
);

  // --------------------------------------------------------------------------
  // Local reset
  // --------------------------------------------------------------------------
  // Dropping load_en clears this domain at once, even with the clock stopped
  wire logic link_arst_n = rstn & load_en;
  logic rst_s1_reg;
  logic rst_s2_reg;
  logic cmp_s1_reg;
  logic cmp_s2_reg;

  always_ff @(posedge load_clock or negedge link_arst_n) begin
    if (!link_arst_n) begin
      rst_s1_reg <= 1'b0;
      rst_s2_reg <= 1'b0;
      cmp_s1_reg <= 1'b0;
      cmp_s2_reg <= 1'b0;
    end else begin
      rst_s1_reg <= 1'b1;
      rst_s2_reg <= rst_s1_reg;
      cmp_s1_reg <= compressed_mode;
      cmp_s2_reg <= cmp_s1_reg;
    end
  end

  // --------------------------------------------------------------------------
  // Byte capture
  // --------------------------------------------------------------------------
  logic [1:0] phase_reg;
  logic [31:0] count_reg;
  pcl_pkg::pcl_byte_t byte_reg;
  logic loaded_reg;

  wire logic phase_hit = !cmp_s2_reg || (phase_reg == `PCL_CMP_PHASE_CAPTURE);
  wire logic take = rst_s2_reg && !loaded_reg && phase_hit;
  wire logic last = (count_reg == 32'(LOAD_BYTES - 1));
  wire logic [1:0] phase_next = cmp_s2_reg ? phase_reg + 2'h1 : `PCL_CMP_PHASE_CAPTURE;

  always_ff @(posedge load_clock or negedge link_arst_n) begin
    if (!link_arst_n) begin
      phase_reg <= `PCL_CMP_PHASE_CAPTURE;
      count_reg <= 32'h0;
      byte_reg <= '0;
      loaded_reg <= 1'b0;
    end else begin
      phase_reg <= (rst_s2_reg && !loaded_reg) ? phase_next : phase_reg;
      byte_reg.valid <= take;
      byte_reg.data <= take ? load_data : byte_reg.data;
      count_reg <= take ? count_reg + 32'h1 : count_reg;
      loaded_reg <= loaded_reg || (take && last);
    end
  end

  // --------------------------------------------------------------------------
  // Falling edges after load_complete rises
  // --------------------------------------------------------------------------
  logic done_s1_reg;
  logic done_s2_reg;
  logic [1:0] fall_reg;
  logic go_reg;

  always_ff @(negedge load_clock or negedge link_arst_n) begin
    if (!link_arst_n) begin
      done_s1_reg <= 1'b0;
      done_s2_reg <= 1'b0;
      fall_reg <= 2'h0;
      go_reg <= 1'b0;
    end else begin
      done_s1_reg <= done_in;
      done_s2_reg <= done_s1_reg;
      fall_reg <= (done_s2_reg && !go_reg) ? fall_reg + 2'h1 : fall_reg;
      go_reg <= go_reg || (done_s2_reg && (fall_reg + 2'h1 == `PCL_INIT_FALL_EDGES));
    end
  end

  assign cfg_byte = byte_reg;
  assign loaded = loaded_reg;
  assign init_go = go_reg;

endmodule : pcl_link_capture

`default_nettype wire

// *** pcl_load_sequencer.sv ***
// Passive parallel configuration load sequencer, device side
`include "pcl_defs.svh"
`timescale 1ns/1ps
`default_nettype none

module pcl_load_sequencer #(
  parameter int LOAD_BYTES = `PCL_DEFAULT_BYTES,
  parameter int POR_CYCLES = `PCL_POR_US * `PCL_CLK_MHZ,
  parameter int INIT_MIN_CYCLES = `PCL_T_CD2UM_MIN_US * `PCL_CLK_MHZ,
  parameter int USR_INIT_PERIODS = `PCL_USR_INIT_PERIODS,
  parameter bit DATA0_USER_IO = 1'b0
) (
  // System clock and reset
  input wire logic clk,
  input wire logic rstn,
  // Link clock and data
  input wire logic load_clock,
  input wire logic [7:0] load_data,
  // Reconfigure request, active low
  input wire logic config_req_n,
  // Status line, open drain, active low
  input wire logic status_n_in,
  output logic status_n_out,
  output logic status_n_oe,
  // load_complete line, open drain
  input wire logic done_in,
  output logic done_out,
  output logic done_oe,
  // Options
  input wire logic compressed_mode,
  input wire logic user_clk_opt,
  input wire logic user_init_clock,
  // Results
  output var pcl_pkg::pcl_byte_t cfg_byte,
  output logic load_active,
  output logic user_mode,
  output logic [7:0] data_user_io_en
);

  // --------------------------------------------------------------------------
  // Timing counts
  // --------------------------------------------------------------------------
  localparam int STATUS_MIN_CYCLES = `PCL_T_STATUS_MIN_US * `PCL_CLK_MHZ;
  localparam int STATUS_MAX_CYCLES = `PCL_T_STATUS_MAX_US * `PCL_CLK_MHZ;
  localparam int REACT_MAX_CYCLES = (`PCL_T_CF2X_MAX_NS * `PCL_CLK_MHZ) / 1000;
  localparam int CNT_W = 20;

  // --------------------------------------------------------------------------
  // Input synchronisers
  // --------------------------------------------------------------------------
  // Bit order: user_init_clock, user_clk_opt, init_go, loaded, done, status, req
  logic [6:0] sync1_reg;
  logic [6:0] sync2_reg;
  logic usr_clk_d_reg;
  logic loaded_w;
  logic init_go_w;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      sync1_reg <= `PCL_SYNC_RST;
      sync2_reg <= `PCL_SYNC_RST;
      usr_clk_d_reg <= 1'b0;
    end else begin
      sync1_reg <= {user_init_clock, user_clk_opt, init_go_w, loaded_w, done_in,
                    status_n_in, config_req_n};
      sync2_reg <= sync1_reg;
      usr_clk_d_reg <= sync2_reg[6];
    end
  end

  wire logic req_low = !sync2_reg[0];
  wire logic status_high = sync2_reg[1];
  wire logic done_high = sync2_reg[2];
  wire logic loaded_s = sync2_reg[3];
  wire logic init_go_s = sync2_reg[4];
  wire logic usr_opt_s = sync2_reg[5];
  // Only slow user clocks are seen; one edge per two system cycles at most
  wire logic usr_rise = sync2_reg[6] && !usr_clk_d_reg;

  // --------------------------------------------------------------------------
  // State and counters
  // --------------------------------------------------------------------------
  pcl_pkg::pcl_state_t state_reg;
  pcl_pkg::pcl_state_t state_next;
  logic [CNT_W-1:0] cnt_reg;
  logic [CNT_W-1:0] usr_cnt_reg;
  logic load_en_reg;

  function automatic logic reached(input logic [CNT_W-1:0] count, input int limit);
    reached = (count >= CNT_W'(limit));
  endfunction : reached

  wire logic por_over = reached(cnt_reg, POR_CYCLES);
  wire logic status_min_over = reached(cnt_reg, STATUS_MIN_CYCLES);
  wire logic osc_init_over = reached(cnt_reg, INIT_MIN_CYCLES);
  wire logic usr_init_over = reached(usr_cnt_reg, USR_INIT_PERIODS);
  wire logic init_time_over = usr_opt_s ? usr_init_over : osc_init_over;

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      pcl_pkg::PCL_POR: begin
        if (por_over) begin
          state_next = req_low ? pcl_pkg::PCL_RESET : pcl_pkg::PCL_RELEASE;
        end
      end
      pcl_pkg::PCL_RESET: begin
        if (!req_low && status_min_over) begin
          state_next = pcl_pkg::PCL_RELEASE;
        end
      end
      pcl_pkg::PCL_RELEASE: begin
        if (status_high) begin
          state_next = pcl_pkg::PCL_LOAD;
        end
      end
      pcl_pkg::PCL_LOAD: begin
        if (!status_high) begin
          state_next = pcl_pkg::PCL_RESET;
        end else if (loaded_s) begin
          state_next = pcl_pkg::PCL_DONE_WAIT;
        end
      end
      pcl_pkg::PCL_DONE_WAIT: begin
        if (done_high) begin
          state_next = pcl_pkg::PCL_INIT;
        end
      end
      pcl_pkg::PCL_INIT: begin
        if (init_go_s && init_time_over) begin
          state_next = pcl_pkg::PCL_USER;
        end
      end
      pcl_pkg::PCL_USER: begin
        state_next = pcl_pkg::PCL_USER;
      end
      default: begin
        state_next = pcl_pkg::PCL_RESET;
      end
    endcase
    if (req_low && state_reg != pcl_pkg::PCL_POR) begin
      state_next = pcl_pkg::PCL_RESET;
    end
  end

  wire logic state_change = (state_next != state_reg);
  wire logic [CNT_W-1:0] cnt_next = state_change ? '0 :
                                    (&cnt_reg ? cnt_reg : cnt_reg + 1'b1);
  wire logic [CNT_W-1:0] usr_cnt_next = (state_reg != pcl_pkg::PCL_INIT) ? '0 :
                                        (usr_rise && !(&usr_cnt_reg)) ?
                                        usr_cnt_reg + 1'b1 : usr_cnt_reg;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state_reg <= pcl_pkg::PCL_POR;
      cnt_reg <= '0;
      usr_cnt_reg <= '0;
    end else begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
      usr_cnt_reg <= usr_cnt_next;
    end
  end

  // --------------------------------------------------------------------------
  // Pin drive
  // --------------------------------------------------------------------------
  // Drives follow the next state so the request is answered one cycle sooner
  wire logic status_drive = (state_next == pcl_pkg::PCL_POR) ||
                            (state_next == pcl_pkg::PCL_RESET);
  wire logic done_drive = (state_next == pcl_pkg::PCL_POR) ||
                          (state_next == pcl_pkg::PCL_RESET) ||
                          (state_next == pcl_pkg::PCL_RELEASE) ||
                          (state_next == pcl_pkg::PCL_LOAD);
  wire logic load_en_next = (state_next == pcl_pkg::PCL_LOAD) ||
                            (state_next == pcl_pkg::PCL_DONE_WAIT) ||
                            (state_next == pcl_pkg::PCL_INIT);
  wire logic user_next = (state_next == pcl_pkg::PCL_USER);
  wire logic [7:0] io_en_next = user_next ? {`PCL_USER_IO_UPPER, DATA0_USER_IO} : 8'h00;

  pcl_pkg::pcl_od_t status_pin_reg;
  pcl_pkg::pcl_od_t done_pin_reg;
  logic user_reg;
  logic [7:0] io_en_reg;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      status_pin_reg <= '{out: `PCL_OD_LOW, oe: 1'b1};
      done_pin_reg <= '{out: `PCL_OD_LOW, oe: 1'b1};
      load_en_reg <= 1'b0;
      user_reg <= 1'b0;
      io_en_reg <= 8'h00;
    end else begin
      status_pin_reg <= '{out: `PCL_OD_LOW, oe: status_drive};
      done_pin_reg <= '{out: `PCL_OD_LOW, oe: done_drive};
      load_en_reg <= load_en_next;
      user_reg <= user_next;
      io_en_reg <= io_en_next;
    end
  end

  assign status_n_out = status_pin_reg.out;
  assign status_n_oe = status_pin_reg.oe;
  assign done_out = done_pin_reg.out;
  assign done_oe = done_pin_reg.oe;
  assign load_active = load_en_reg;
  assign user_mode = user_reg;
  assign data_user_io_en = io_en_reg;

  // --------------------------------------------------------------------------
  // Link domain
  // --------------------------------------------------------------------------
  // Bytes stay in the link domain; a system-clock crossing could not keep up
  pcl_link_capture #(
    .LOAD_BYTES(LOAD_BYTES)
  ) u_link (
    .load_clock(load_clock),
    .rstn(rstn),
    .load_en(load_en_reg),
    .load_data(load_data),
    .compressed_mode(compressed_mode),
    .done_in(done_in),
    .cfg_byte(cfg_byte),
    .loaded(loaded_w),
    .init_go(init_go_w)
  );

endmodule : pcl_load_sequencer

`default_nettype wire

// *** pcl_load_monitor.sv ***
// Concurrent checks on the pins of the load sequencer
`timescale 1ns/1ps
`default_nettype none

module pcl_load_monitor #(
  parameter int LOAD_BYTES = 16,
  parameter int POR_CYCLES = 1200,
  parameter int INIT_MIN_CYCLES = 5500,
  parameter int USR_INIT_PERIODS = 8532,
  parameter bit DATA0_USER_IO = 1'b0
) (
  // Clocks and reset
  input wire logic clk,
  input wire logic rstn,
  input wire logic load_clock,
  // Pins
  input wire logic [7:0] load_data,
  input wire logic config_req_n,
  input wire logic status_n_in,
  input wire logic status_n_out,
  input wire logic status_n_oe,
  input wire logic done_in,
  input wire logic done_out,
  input wire logic done_oe,
  input wire logic compressed_mode,
  input wire logic user_clk_opt,
  input wire logic user_init_clock,
  // Results
  input wire pcl_pkg::pcl_byte_t cfg_byte,
  input wire logic load_active,
  input wire logic user_mode,
  input wire logic [7:0] data_user_io_en
);
  // ----------------------------------------------------------------------
  // Helper counters
  // ----------------------------------------------------------------------
  logic [15:0] low_cnt_reg;
  logic [15:0] init_cnt_reg;
  logic [15:0] uclk_cnt_reg;
  logic por_reg;
  logic uclk_reg;
  wire logic init_run = done_in && !done_oe && !user_mode;
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      low_cnt_reg <= 16'h0000;
      init_cnt_reg <= 16'h0000;
      uclk_cnt_reg <= 16'h0000;
      por_reg <= 1'b1;
      uclk_reg <= 1'b0;
    end else begin
      low_cnt_reg <= status_n_oe ? low_cnt_reg + 16'h0001 : 16'h0000;
      init_cnt_reg <= done_oe ? 16'h0000 : init_cnt_reg + 16'(init_run);
      uclk_cnt_reg <= done_oe ? 16'h0000 :
                      uclk_cnt_reg + 16'(init_run && user_init_clock && !uclk_reg);
      por_reg <= por_reg && status_n_oe;
      uclk_reg <= user_init_clock;
    end
  end
  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  sequence req_fall_s;
    $fell(config_req_n);
  endsequence
  sequence lines_pulled_s;
    ##[1:4] (status_n_oe && done_oe && !user_mode);
  endsequence
  req_restart_a: assert property (@(posedge clk) disable iff (!rstn)
    req_fall_s |-> lines_pulled_s) else $error("request fall not answered");
  status_min_a: assert property (@(posedge clk) disable iff (!rstn)
    $fell(status_n_oe) |-> low_cnt_reg >= (por_reg ? POR_CYCLES - 1 : 1000))
    else $error("status pulse too short");
  status_max_a: assert property (@(posedge clk) disable iff (!rstn)
    status_n_oe && config_req_n |-> low_cnt_reg < 16'd50000) else $error("status held too long");
  done_low_a: assert property (@(posedge clk) disable iff (!rstn)
    status_n_oe || $rose(load_active) |-> done_oe) else $error("done line not held low");
  user_excl_a: assert property (@(posedge clk) disable iff (!rstn)
    user_mode |-> !load_active && !status_n_oe && !done_oe) else $error("user mode while loading");
  io_user_a: assert property (@(posedge clk) disable iff (!rstn)
    user_mode == $past(user_mode) |->
    data_user_io_en == (user_mode ? {7'h7f, DATA0_USER_IO} : 8'h00))
    else $error("data pin ownership wrong");
  init_min_a: assert property (@(posedge clk) disable iff (!rstn)
    $rose(user_mode) && !user_clk_opt |-> init_cnt_reg >= INIT_MIN_CYCLES)
    else $error("user mode too early");
  init_max_a: assert property (@(posedge clk) disable iff (!rstn)
    !user_clk_opt |-> init_cnt_reg <= 16'd15000) else $error("user mode too late");
  user_clk_a: assert property (@(posedge clk) disable iff (!rstn)
    $rose(user_mode) && user_clk_opt |-> uclk_cnt_reg >= USR_INIT_PERIODS)
    else $error("too few user clock periods");
  byte_capture_a: assert property (@(posedge load_clock) disable iff (!rstn)
    cfg_byte.valid |-> cfg_byte.data == $past(load_data)) else $error("byte not taken on rise");
  cmp_gap_a: assert property (@(posedge load_clock) disable iff (!rstn)
    cfg_byte.valid && compressed_mode |=> !cfg_byte.valid [*3]) else $error("capture gap wrong");
endmodule : pcl_load_monitor

bind pcl_load_sequencer pcl_load_monitor #(.LOAD_BYTES(LOAD_BYTES), .POR_CYCLES(POR_CYCLES),
  .INIT_MIN_CYCLES(INIT_MIN_CYCLES), .USR_INIT_PERIODS(USR_INIT_PERIODS),
  .DATA0_USER_IO(DATA0_USER_IO)) pcl_load_monitor_i (.clk(clk), .rstn(rstn),
  .load_clock(load_clock), .load_data(load_data), .config_req_n(config_req_n),
  .status_n_in(status_n_in), .status_n_out(status_n_out), .status_n_oe(status_n_oe),
  .done_in(done_in), .done_out(done_out), .done_oe(done_oe), .compressed_mode(compressed_mode),
  .user_clk_opt(user_clk_opt), .user_init_clock(user_init_clock), .cfg_byte(cfg_byte),
  .load_active(load_active), .user_mode(user_mode), .data_user_io_en(data_user_io_en));
`default_nettype wire

// *** pcl_host_model.sv ***
// Behavioural configuration host on the far side of the load pins
`timescale 1ns/1ps
`default_nettype none

module pcl_host_model #(
  parameter int CF2CK_NS = 500000,
  parameter int ST2CK_NS = 2000
) (
  // Driven by the host
  output logic load_clock,
  output logic [7:0] load_data,
  output logic config_req_n,
  output logic status_hold_n,
  output logic user_init_clock,
  // Sensed wires
  input wire logic status_n,
  input wire logic load_complete
);
  realtime req_rise_t;
  initial begin
    load_clock = 1'b0;
    load_data = 8'h00;
    config_req_n = 1'b1;
    status_hold_n = 1'b1;
    user_init_clock = 1'b0;
    req_rise_t = 0;
  end
  task automatic pulse_req(input int low_ns);
    config_req_n = 1'b0;
    #(low_ns);
    config_req_n = 1'b1;
    req_rise_t = $realtime;
  endtask : pulse_req
  task automatic hold_status(input int ns);
    status_hold_n = 1'b0;
    #(ns);
    status_hold_n = 1'b1;
  endtask : hold_status
  // Clock parks low between frames, never floats
  task automatic cycle();
    #7.5 load_clock = 1'b1;
    #7.5 load_clock = 1'b0;
  endtask : cycle
  task automatic load_bytes(input int n, input bit cmp, input logic [7:0] base);
    wait (status_n === 1'b1);
    #(ST2CK_NS);
    while ($realtime < req_rise_t + CF2CK_NS) #10;
    load_data = ~base;
    repeat (2) cycle();
    for (int i = 0; i < n; i++) begin
      load_data = base + 8'(i * 17);
      repeat (cmp ? 4 : 1) cycle();
    end
  endtask : load_bytes
  task automatic finish_load();
    int k;
    k = 0;
    repeat (3) cycle();
    load_data = ~load_data;
    while (load_complete !== 1'b1 && k < 400) begin
      cycle();
      k++;
    end
    repeat (4) cycle();
  endtask : finish_load
  task automatic run_user_clk(input int n);
    #40;
    repeat (2 * n) #50 user_init_clock = ~user_init_clock;
  endtask : run_user_clk
endmodule : pcl_host_model
`default_nettype wire

// *** testbench.sv ***
// Self-checking bench for the load sequencer
`timescale 1ns/1ps
`default_nettype none

module testbench;
  localparam int NB = 4;
  logic clk, rstn, compressed_mode, user_clk_opt, user_mode, load_active;
  logic load_clock, config_req_n, status_hold_n, user_init_clock;
  logic status_n_out, status_n_oe, done_out, done_oe;
  logic [7:0] load_data, data_user_io_en;
  pcl_pkg::pcl_byte_t cfg_byte;
  // Wired-AND with pull-ups
  wire logic status_n = (status_n_oe ? status_n_out : 1'b1) & status_hold_n;
  wire logic load_complete = done_oe ? done_out : 1'b1;
  int n_errors = 0;
  int n_checks = 0;
  int cyc = 0;
  logic [7:0] got[$];

  // Power-on hold of the design at its default length
  localparam int POR_CYC = 1200;

  pcl_load_sequencer #(.LOAD_BYTES(NB), .USR_INIT_PERIODS(8)) pcl_load_sequencer_i (
    .clk(clk), .rstn(rstn), .load_clock(load_clock), .load_data(load_data),
    .config_req_n(config_req_n), .status_n_in(status_n), .status_n_out(status_n_out),
    .status_n_oe(status_n_oe), .done_in(load_complete), .done_out(done_out),
    .done_oe(done_oe), .compressed_mode(compressed_mode), .user_clk_opt(user_clk_opt),
    .user_init_clock(user_init_clock), .cfg_byte(cfg_byte), .load_active(load_active),
    .user_mode(user_mode), .data_user_io_en(data_user_io_en));
  // Shortened wait after the request keeps the run brief
  pcl_host_model #(.CF2CK_NS(20000)) pcl_host_model_i (.load_clock(load_clock),
    .load_data(load_data), .config_req_n(config_req_n), .status_hold_n(status_hold_n),
    .user_init_clock(user_init_clock), .status_n(status_n), .load_complete(load_complete));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 40000) begin
      $display("[ERR] %0t timeout", $time);
      n_errors++;
      final_report();
    end
  end
  always @(negedge load_clock) if (cfg_byte.valid === 1'b1) got.push_back(cfg_byte.data);

  task automatic chk(input logic [7:0] g, input logic [7:0] e, input string m);
    n_checks++;
    if (g !== e) begin
      n_errors++;
      $display("[ERR] %0t %s: got %h expected %h", $time, m, g, e);
    end
  endtask : chk
  task automatic wait_user();
    for (int k = 0; k < 7000 && user_mode !== 1'b1; k++) @(posedge clk);
    #1;
  endtask : wait_user
  task automatic t_power_on();
    int k;
    k = 0;
    chk(8'(status_n_oe), 8'h01, "status low at power-up");
    chk(8'(done_oe), 8'h01, "done low at power-up");
    while (status_n !== 1'b1 && k < POR_CYC + 100) begin
      @(posedge clk);
      k++;
    end
    chk(8'(k >= POR_CYC && k < POR_CYC + 100), 8'h01, "power-on hold length");
    $display("power-on test done");
  endtask : t_power_on
  task automatic t_load(input bit cmp, input bit uopt, input logic [7:0] base);
    @(posedge clk);
    #1;
    compressed_mode = cmp;
    user_clk_opt = uopt;
    pcl_host_model_i.load_bytes(NB, cmp, base);
    pcl_host_model_i.finish_load();
    chk(8'(load_complete), 8'h01, "done released after last byte");
    if (uopt) pcl_host_model_i.run_user_clk(12);
    wait_user();
    chk(8'(user_mode), 8'h01, "user mode reached");
    @(posedge clk);
    #1;
    chk(data_user_io_en, 8'hfe, "data pins handed to user");
    chk(8'(got.size()), 8'(NB), "byte count");
    foreach (got[i]) chk(got[i], base + 8'(i * 17), "byte value");
    got.delete();
    $display("load test done, compressed %0d user clock %0d", cmp, uopt);
  endtask : t_load
  task automatic t_reconfig();
    @(posedge clk);
    #1;
    fork
      pcl_host_model_i.pulse_req(2000);
      begin
        repeat (5) @(posedge clk);
        #1;
        chk(8'(status_n_oe & done_oe), 8'h01, "lines pulled after request");
        chk(8'(user_mode), 8'h00, "user mode left");
      end
    join
    pcl_host_model_i.hold_status(12000);
    chk(8'(status_n_oe), 8'h00, "device released status");
    chk(8'(load_active), 8'h00, "loading held off by external hold");
    repeat (10) @(posedge clk);
    #1;
    chk(8'(load_active), 8'h01, "loading starts after hold");
    $display("reconfigure test done");
  endtask : t_reconfig
  task automatic t_error();
    @(posedge clk);
    #1;
    pcl_host_model_i.load_bytes(2, 1'b0, 8'h50);
    pcl_host_model_i.hold_status(100);
    repeat (2) @(posedge clk);
    #1;
    chk(8'(status_n_oe), 8'h01, "status pulled after load error");
    chk(8'(done_oe), 8'h01, "done held after load error");
    got.delete();
    $display("error test done");
    t_reconfig();
  endtask : t_error
  task automatic final_report();
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : final_report

  initial begin
    rstn = 1'b0;
    compressed_mode = 1'b0;
    user_clk_opt = 1'b0;
    repeat (5) @(posedge clk);
    #1 rstn = 1'b1;
    t_power_on();
    t_load(1'b0, 1'b0, 8'h11);
    t_reconfig();
    t_load(1'b1, 1'b1, 8'h83);
    t_reconfig();
    t_error();
    t_load(1'b0, 1'b0, 8'h2c);
    final_report();
  end
endmodule : testbench
`default_nettype wire
